// ---- hw/drt_channel.sv ----
/*
 One reload timer channel: down counter, reload value, high-byte
 holding register and zero-reached flag.
 Assumes strobes from the register decoder are single-cycle and a
 shared prescale tick that is high one cycle in every period.
*/
`timescale 1ns/1ns
`default_nettype none

module drt_channel (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic tick,
	input wire logic count_en,
	input wire logic flag_clr,
	input wire logic [7:0] wdata,
	input wire drt_pkg::drt_chan_ctl_s ctl,
	output var drt_pkg::drt_chan_stat_s stat
);

	logic [15:0] count_next;
	logic [15:0] reload_next;
	logic [7:0] hold_next;
	logic hold_valid_next;
	logic flag_next;
	logic cnt_wr;
	logic step;
	logic hit_zero;

	// Software writes take priority over a decrement in the same cycle
	assign cnt_wr = ctl.cnt_lo_wr | ctl.cnt_hi_wr;
	assign step = tick & count_en & ~cnt_wr;
	assign hit_zero = step & (stat.count == 16'h0001);

	// Decrement, refill at zero; a written zero also refills
	assign count_next = ctl.cnt_lo_wr ? {stat.count[15:8], wdata} :
		ctl.cnt_hi_wr ? {wdata, stat.count[7:0]} :
		(step && stat.count <= 16'h0001) ? stat.reload :
		step ? stat.count - 16'h0001 : stat.count;

	// Reload value kept as two independent bytes
	assign reload_next = ctl.rld_lo_wr ? {stat.reload[15:8], wdata} :
		ctl.rld_hi_wr ? {wdata, stat.reload[7:0]} : stat.reload;

	// Low read freezes the high byte for the following high read
	assign hold_next = ctl.cnt_lo_rd ? stat.count[15:8] : stat.hold_hi;
	assign hold_valid_next = ctl.cnt_lo_rd | (stat.hold_valid & ~ctl.cnt_hi_rd);

	// Set wins over clear so a zero in the clearing cycle is kept
	assign flag_next = hit_zero | (stat.zero_flag & ~flag_clr);

	// Channel state
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			stat.count <= drt_pkg::COUNT_RESET;
			stat.reload <= drt_pkg::RELOAD_RESET;
			stat.hold_hi <= 8'h00;
			stat.hold_valid <= 1'b0;
			stat.zero_flag <= 1'b0;
		end
		else
		begin
			stat.count <= count_next;
			stat.reload <= reload_next;
			stat.hold_hi <= hold_next;
			stat.hold_valid <= hold_valid_next;
			stat.zero_flag <= flag_next;
		end
	end

	// Checks on counting behaviour
	a_reload_reset: assert property (@(posedge clk_sys)
		$fell(reset) |-> stat.reload == 16'hffff)
		else $error("reload value not all ones after reset");
	a_refill_zero: assert property (@(posedge clk_sys) disable iff (reset)
		(step && stat.count == 16'h0001) |=> stat.count == $past(stat.reload))
		else $error("counter not refilled at zero");
	a_count_step: assert property (@(posedge clk_sys) disable iff (reset)
		(step && stat.count > 16'h0001) |=> stat.count == $past(stat.count) - 16'h0001)
		else $error("counter did not decrement by one");
	a_stopped_hold: assert property (@(posedge clk_sys) disable iff (reset)
		(!count_en && !cnt_wr) |=> $stable(stat.count))
		else $error("counter moved while disabled");
	a_flag_set: assert property (@(posedge clk_sys) disable iff (reset)
		hit_zero |=> stat.zero_flag ##1 (stat.zero_flag || $past(flag_clr)))
		else $error("zero flag not set on reaching zero");
	c_refill: cover property (@(posedge clk_sys) disable iff (reset)
		step && stat.count == 16'h0001);

endmodule : drt_channel

`default_nettype wire

// ---- hw/drt_pkg.sv ----
/*
 Package for the dual reload timer register block: I/O addresses,
 control register layout, reset values, prescale count and carriers.
 Assumes a byte-wide on-chip I/O space with 8-bit addresses.
*/
package drt_pkg;

	// Byte addresses in on-chip I/O space
	localparam logic [7:0] ADDR_COUNT0_LOW = 8'h0c;
	localparam logic [7:0] ADDR_COUNT0_HIGH = 8'h0d;
	localparam logic [7:0] ADDR_RELOAD0_LOW = 8'h0e;
	localparam logic [7:0] ADDR_RELOAD0_HIGH = 8'h0f;
	localparam logic [7:0] ADDR_TIMER_CTRL = 8'h10;
	localparam logic [7:0] ADDR_COUNT1_LOW = 8'h14;
	localparam logic [7:0] ADDR_COUNT1_HIGH = 8'h15;
	localparam logic [7:0] ADDR_RELOAD1_LOW = 8'h16;
	localparam logic [7:0] ADDR_RELOAD1_HIGH = 8'h17;

	// Control register fields
	localparam int CTRL_ENABLE_LSB = 0;
	localparam int CTRL_ZERO_LSB = 6;

	// Reset values
	localparam logic [15:0] COUNT_RESET = 16'hffff;
	localparam logic [15:0] RELOAD_RESET = 16'hffff;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] RDATA_IDLE = 8'h00;

	// System clocks per counter decrement
	localparam int TICK_CYCLES = 20;

	// Per-channel access strobes, one cycle each
	typedef struct packed {
		logic cnt_lo_wr;
		logic cnt_hi_wr;
		logic rld_lo_wr;
		logic rld_hi_wr;
		logic cnt_lo_rd;
		logic cnt_hi_rd;
	} drt_chan_ctl_s;

	// Per-channel state seen by the register side
	typedef struct packed {
		logic [15:0] count;
		logic [15:0] reload;
		logic [7:0] hold_hi;
		logic hold_valid;
		logic zero_flag;
	} drt_chan_stat_s;

endpackage : drt_pkg

// ---- hw/drt_regs.sv ----
/*
 Top of the dual reload timer: byte-wide I/O register decode, shared
 divide-by-twenty prescaler, control register and two channels.
 Assumes the processor issues at most one single-cycle read or write
 strobe per clock, with address and data valid alongside it.
*/
//
// Contract
// - Each channel's 16-bit reload value is reached as low and high bytes.
// - Reset loads both reload values with all ones.
// - A counter reaching zero refills from its reload value and counts on.
// - Channel 0 reload bytes sit at 0EH and 0FH, read and write.
// - Channel 1 reload bytes sit at 16H and 17H, read and write.
// - Channel 0 counter bytes sit at 0CH and 0DH, read and write.
// - Channel 1 counter bytes sit at 14H and 15H, read and write.
// - An enabled counter decrements once every twenty system clocks.
// - Low byte read latches high byte; next high read returns the latch.
// - Counting only while enable bit is one; bit clears on reset.
// - Zero flag sets at zero; clears on control read then counter read.
`timescale 1ns/1ns
`default_nettype none

module drt_regs #(
	parameter int TICK_CYCLES = drt_pkg::TICK_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [7:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	output logic [1:0] zero_reached
);

	localparam int DIV_W = $clog2(TICK_CYCLES);

	// Prescaler below two cycles cannot pace a decrement
	if (TICK_CYCLES < 2)
	begin : g_bad_tick
		$error("TICK_CYCLES must be at least 2");
	end

	// Strobes for one channel from its four addresses
	function automatic drt_pkg::drt_chan_ctl_s chan_decode(
		input logic [7:0] addr,
		input logic [7:0] cnt_lo,
		input logic [7:0] cnt_hi,
		input logic [7:0] rld_lo,
		input logic [7:0] rld_hi,
		input logic wr,
		input logic rd
	);
		drt_pkg::drt_chan_ctl_s c;
		c.cnt_lo_wr = wr && addr == cnt_lo;
		c.cnt_hi_wr = wr && addr == cnt_hi;
		c.rld_lo_wr = wr && addr == rld_lo;
		c.rld_hi_wr = wr && addr == rld_hi;
		c.cnt_lo_rd = rd && addr == cnt_lo;
		c.cnt_hi_rd = rd && addr == cnt_hi;
		return c;
	endfunction : chan_decode

	drt_pkg::drt_chan_ctl_s ctl0;
	drt_pkg::drt_chan_ctl_s ctl1;
	drt_pkg::drt_chan_stat_s stat0;
	drt_pkg::drt_chan_stat_s stat1;
	logic [DIV_W-1:0] div_reg;
	logic [DIV_W-1:0] div_next;
	logic tick_reg;
	logic tick_next;
	logic [1:0] enable_reg;
	logic [1:0] enable_next;
	logic [1:0] arm_reg;
	logic [1:0] arm_next;
	logic [1:0] flag_clr;
	logic [1:0] cnt_rd;
	logic ctrl_wr;
	logic ctrl_rd;
	logic [7:0] ctrl_view;
	logic [7:0] rdata_next;
	logic [7:0] hi0_view;
	logic [7:0] hi1_view;

	// Address decode, same function for both channels
	assign ctl0 = chan_decode(io_addr, drt_pkg::ADDR_COUNT0_LOW,
		drt_pkg::ADDR_COUNT0_HIGH, drt_pkg::ADDR_RELOAD0_LOW,
		drt_pkg::ADDR_RELOAD0_HIGH, io_wr, io_rd);
	assign ctl1 = chan_decode(io_addr, drt_pkg::ADDR_COUNT1_LOW,
		drt_pkg::ADDR_COUNT1_HIGH, drt_pkg::ADDR_RELOAD1_LOW,
		drt_pkg::ADDR_RELOAD1_HIGH, io_wr, io_rd);
	assign ctrl_wr = io_wr && io_addr == drt_pkg::ADDR_TIMER_CTRL;
	assign ctrl_rd = io_rd && io_addr == drt_pkg::ADDR_TIMER_CTRL;

	// Free-running prescaler shared by both channels
	assign div_next = (div_reg == DIV_W'(TICK_CYCLES - 1)) ? '0 :
		div_reg + DIV_W'(1);
	assign tick_next = (div_reg == DIV_W'(TICK_CYCLES - 1));

	// Enable bits writable; flags are read-only from software
	assign enable_next = ctrl_wr ?
		io_wdata[drt_pkg::CTRL_ENABLE_LSB +: 2] : enable_reg;

	// Control read arms the clear; a counter byte read fires it
	assign cnt_rd = {ctl1.cnt_lo_rd | ctl1.cnt_hi_rd,
		ctl0.cnt_lo_rd | ctl0.cnt_hi_rd};
	assign flag_clr = arm_reg & cnt_rd;
	assign arm_next = ctrl_rd ? 2'b11 : (arm_reg & ~cnt_rd);

	// High byte returns the latch only after a matching low read
	assign hi0_view = stat0.hold_valid ? stat0.hold_hi : stat0.count[15:8];
	assign hi1_view = stat1.hold_valid ? stat1.hold_hi : stat1.count[15:8];
	assign ctrl_view = {stat1.zero_flag, stat0.zero_flag, 4'h0, enable_reg};

	// Read mux; unmapped addresses read as zero
	assign rdata_next = !io_rd ? drt_pkg::RDATA_IDLE :
		(io_addr == drt_pkg::ADDR_COUNT0_LOW) ? stat0.count[7:0] :
		(io_addr == drt_pkg::ADDR_COUNT0_HIGH) ? hi0_view :
		(io_addr == drt_pkg::ADDR_RELOAD0_LOW) ? stat0.reload[7:0] :
		(io_addr == drt_pkg::ADDR_RELOAD0_HIGH) ? stat0.reload[15:8] :
		(io_addr == drt_pkg::ADDR_COUNT1_LOW) ? stat1.count[7:0] :
		(io_addr == drt_pkg::ADDR_COUNT1_HIGH) ? hi1_view :
		(io_addr == drt_pkg::ADDR_RELOAD1_LOW) ? stat1.reload[7:0] :
		(io_addr == drt_pkg::ADDR_RELOAD1_HIGH) ? stat1.reload[15:8] :
		(io_addr == drt_pkg::ADDR_TIMER_CTRL) ? ctrl_view :
		drt_pkg::RDATA_IDLE;

	// Register block state
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			div_reg <= '0;
			tick_reg <= 1'b0;
			enable_reg <= drt_pkg::CTRL_RESET[1:0];
			arm_reg <= 2'b00;
			io_rdata <= drt_pkg::RDATA_IDLE;
		end
		else
		begin
			div_reg <= div_next;
			tick_reg <= tick_next;
			enable_reg <= enable_next;
			arm_reg <= arm_next;
			io_rdata <= rdata_next;
		end
	end

	// Flag copies for the outside; one cycle behind the channel
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			zero_reached <= 2'b00;
		else
			zero_reached <= {stat1.zero_flag, stat0.zero_flag};
	end

	// Two identical channels, differing in decode, enable bit and flag clear
	drt_channel u_chan0 (
		.clk_sys(clk_sys),
		.reset(reset),
		.tick(tick_reg),
		.count_en(enable_reg[0]),
		.flag_clr(flag_clr[0]),
		.wdata(io_wdata),
		.ctl(ctl0),
		.stat(stat0)
	);

	drt_channel u_chan1 (
		.clk_sys(clk_sys),
		.reset(reset),
		.tick(tick_reg),
		.count_en(enable_reg[1]),
		.flag_clr(flag_clr[1]),
		.wdata(io_wdata),
		.ctl(ctl1),
		.stat(stat1)
	);

	// Cycles since the last tick, for the period check only
	logic [7:0] gap_reg;
	logic seen_reg;
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			gap_reg <= 8'h00;
			seen_reg <= 1'b0;
		end
		else
		begin
			gap_reg <= tick_reg ? 8'h00 : gap_reg + 8'h01;
			seen_reg <= seen_reg | tick_reg;
		end
	end

	a_tick_period: assert property (@(posedge clk_sys) disable iff (reset)
		(tick_reg && seen_reg) |-> gap_reg == 8'(TICK_CYCLES - 1))
		else $error("decrement tick period wrong");
	a_reload0_write: assert property (@(posedge clk_sys) disable iff (reset)
		(io_wr && io_addr == 8'h0e) ##1 (io_rd && io_addr == 8'h0e && !io_wr)
		|=> io_rdata == $past(io_wdata, 2))
		else $error("reload 0 low byte not read back");
	a_reload1_write: assert property (@(posedge clk_sys) disable iff (reset)
		(io_wr && io_addr == 8'h17) |=> stat1.reload[15:8] == $past(io_wdata))
		else $error("reload 1 high byte not written");
	a_count0_read: assert property (@(posedge clk_sys) disable iff (reset)
		(io_rd && io_addr == 8'h0c) |=> io_rdata == $past(stat0.count[7:0]))
		else $error("counter 0 low byte read wrong");
	a_count1_write: assert property (@(posedge clk_sys) disable iff (reset)
		(io_wr && io_addr == 8'h14) |=> stat1.count[7:0] == $past(io_wdata))
		else $error("counter 1 low byte not written");
	a_hold_read: assert property (@(posedge clk_sys) disable iff (reset)
		(io_rd && io_addr == 8'h0c) ##1 (io_rd && io_addr == 8'h0d)
		|=> io_rdata == $past(stat0.count[15:8], 2))
		else $error("high read did not return latched byte");
	a_flag_clear: assert property (@(posedge clk_sys) disable iff (reset)
		(ctrl_rd ##1 (ctl1.cnt_lo_rd && !u_chan1.hit_zero) ##0 1'b1) or
		(arm_reg[1] && cnt_rd[1] && !(u_chan1.hit_zero))
		|=> !stat1.zero_flag)
		else $error("zero flag not cleared by read sequence");
	a_enable_gate: assert property (@(posedge clk_sys) disable iff (reset)
		(!enable_reg[0] && !ctl0.cnt_lo_wr && !ctl0.cnt_hi_wr)
		|=> stat0.count == $past(stat0.count))
		else $error("counter 0 moved while disabled");
	c_flag_cleared: cover property (@(posedge clk_sys) disable iff (reset)
		stat0.zero_flag ##1 ctrl_rd ##[1:4] (cnt_rd[0] && arm_reg[0]));
	c_hold_used: cover property (@(posedge clk_sys) disable iff (reset)
		ctl0.cnt_lo_rd ##[1:8] ctl0.cnt_hi_rd);
	c_both_zero: cover property (@(posedge clk_sys) disable iff (reset)
		stat0.zero_flag && stat1.zero_flag);

endmodule : drt_regs

`default_nettype wire

// ---- verification/drt_regs_test.sv ----
/*
 Self-checking bench for the dual reload timer register block.
 Assumes drt_regs with its default prescale count of twenty and the
 one-cycle byte-wide I/O strobes described for it.
*/
`timescale 1ns/1ns
`default_nettype none

`define CHK(what, exp, got) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) \
		begin \
			$display("[FAIL] %s expected %h seen %h", what, exp, got); \
			miscompares++; \
		end \
	end

module drt_regs_test;

	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [7:0] io_addr = 8'h00;
	logic io_wr = 1'b0;
	logic io_rd = 1'b0;
	logic [7:0] io_wdata = 8'h00;
	logic [7:0] io_rdata;
	logic [1:0] zero_reached;
	int miscompares = 0;
	int samples_checked = 0;
	logic [7:0] rd8;
	logic [15:0] v1;
	logic [15:0] v2;
	logic [7:0] base;
	logic [7:0] map_addr [8] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f,
		8'h14, 8'h15, 8'h16, 8'h17};

	drt_regs i_dut (
		.clk_sys(clk_sys),
		.reset(reset),
		.io_addr(io_addr),
		.io_wr(io_wr),
		.io_rd(io_rd),
		.io_wdata(io_wdata),
		.io_rdata(io_rdata),
		.zero_reached(zero_reached)
	);

	// 125 MHz system clock
	always #4 clk_sys = ~clk_sys;

	// Idle cycles; callers always sit 1 ns past a rising edge
	task automatic idle(input int n);
		repeat (n)
		begin
			@(posedge clk_sys);
			#1;
		end
	endtask : idle

	// One-cycle write strobe, taken at the next edge
	task automatic io_write(input logic [7:0] a, input logic [7:0] d);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		idle(1);
		io_wr = 1'b0;
	endtask : io_write

	// Read data is registered, so it is valid just after the taking edge
	task automatic io_read(input logic [7:0] a, output logic [7:0] d);
		io_addr = a;
		io_rd = 1'b1;
		idle(1);
		io_rd = 1'b0;
		d = io_rdata;
	endtask : io_read

	// Low byte first so the high byte comes from the holding register
	task automatic read16(input logic [7:0] a, output logic [15:0] v);
		logic [7:0] lo;
		logic [7:0] hi;
		io_read(a, lo);
		io_read(a + 8'h01, hi);
		v = {hi, lo};
	endtask : read16

	task automatic final_report;
		if (miscompares == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report

	// Whole run is a few hundred cycles; this cuts a hang short
	initial
	begin
		#200000;
		miscompares++;
		final_report();
	end

	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk_sys);
		#1;
		reset = 1'b0;
		foreach (map_addr[i])
		begin
			io_read(map_addr[i], rd8);
			`CHK("reset byte", 8'hff, rd8)
		end
		io_read(8'h10, rd8);
		`CHK("ctrl reset", 8'h00, rd8)
		io_write(8'h11, 8'hff);
		io_read(8'h11, rd8);
		`CHK("unmapped read", 8'h00, rd8)
		io_write(8'h10, 8'hfc);
		io_read(8'h10, rd8);
		`CHK("ctrl ro bits", 8'h00, rd8)
		// Reload bytes of both channels, distinct per byte and channel
		for (int c = 0; c < 2; c++)
		begin
			base = (c == 0) ? 8'h0c : 8'h14;
			io_write(base + 8'h02, 8'h5a ^ 8'(c));
			io_write(base + 8'h03, 8'ha5 ^ 8'(c));
			read16(base + 8'h02, v1);
			`CHK("reload rw", {8'ha5 ^ 8'(c), 8'h5a ^ 8'(c)}, v1)
		end
		// Write then read straight after, back to back on the bus
		io_write(8'h0e, 8'h3c);
		io_read(8'h0e, rd8);
		`CHK("reload0 low back", 8'h3c, rd8)
		// Holding register: live high byte changed between the two reads
		io_write(8'h0c, 8'h34);
		io_write(8'h0d, 8'h12);
		io_read(8'h0c, rd8);
		`CHK("count low", 8'h34, rd8)
		io_write(8'h0d, 8'h56);
		io_read(8'h0d, rd8);
		`CHK("held high", 8'h12, rd8)
		io_read(8'h0d, rd8);
		`CHK("live high", 8'h56, rd8)
		// Rate: reads exactly 200 clocks apart see ten decrements
		io_write(8'h0d, 8'h08);
		io_write(8'h10, 8'h01);
		read16(8'h0c, v1);
		idle(198);
		read16(8'h0c, v2);
		`CHK("ticks in 200", 16'd10, v1 - v2)
		io_write(8'h10, 8'h00);
		read16(8'h0c, v1);
		idle(60);
		read16(8'h0c, v2);
		`CHK("stopped count", v1, v2)
		// Reach zero, refill and flag handling on each channel in turn
		for (int c = 0; c < 2; c++)
		begin
			base = (c == 0) ? 8'h0c : 8'h14;
			io_write(base + 8'h02, 8'h07 + 8'(c));
			io_write(base + 8'h03, 8'h00);
			io_write(base, 8'h02);
			io_write(base + 8'h01, 8'h00);
			read16(base, v1);
			`CHK("count written", 16'h0002, v1)
			io_write(8'h10, 8'h01 << c);
			for (int k = 0; k < 100 && zero_reached[c] !== 1'b1; k++)
				idle(1);
			`CHK("flag set", 1'b1, zero_reached[c])
			`CHK("other flag", 1'b0, zero_reached[1 - c])
			read16(base, v1);
			`CHK("refilled", 16'h0007 + 16'(c), v1)
			io_write(8'h10, 8'h00);
			idle(2);
			`CHK("flag kept", 1'b1, zero_reached[c])
			io_read(8'h10, rd8);
			`CHK("ctrl flag", 8'h40 << c, rd8)
			io_read(base + 8'h01, rd8);
			idle(2);
			`CHK("flag cleared", 1'b0, zero_reached[c])
		end
		final_report();
	end

endmodule : drt_regs_test

`undef CHK
`default_nettype wire
